// >>> src/card_socket_defs.vh
`ifndef CARD_SOCKET_DEFS_VH
`define CARD_SOCKET_DEFS_VH

// register byte offsets from the socket base
`define ADDR_FORCE_EVENT 8'h0c
`define ADDR_SOCKET_CTRL 8'h10
`define ADDR_POWER_MGMT 8'h20

// voltage and clock control register fields
`define CTRL_HALT_POLICY_BIT 7
`define CTRL_SUPPLY_MSB 6
`define CTRL_SUPPLY_LSB 4
`define CTRL_PROG_MSB 2
`define CTRL_PROG_LSB 0
`define CTRL_RESET 32'h00000000
`define CTRL_WR_MASK 32'h000000f7

// idle clock management register fields
`define PM_ACCESS_BIT 25
`define PM_CHANGED_BIT 24
`define PM_UNLOCK_BIT 16
`define PM_ACTION_BIT 0
`define PM_RESET 32'h00000000
`define PM_WR_MASK 32'h00010001

// force event register, write-only bits
`define FORCE_INTERROGATE_BIT 14
`define FORCE_VCLASS_MSB 13
`define FORCE_VCLASS_LSB 10

// voltage request codes
`define VOLT_OFF 3'h0
`define VOLT_12V 3'h1
`define VOLT_5V 3'h2
`define VOLT_3V3 3'h3
`define VOLT_ALT_X 3'h4
`define VOLT_ALT_Y 3'h5
`define VOLT_RSVD_A 3'h6
`define VOLT_RSVD_B 3'h7

// slowed card clock divides by this count
`define SLOW_DIVIDE 16
`define SLOW_DIV_W 4

`endif

// >>> src/card_socket_power_clock_ctrl.v
`timescale 1ns/1ps
`include "card_socket_defs.vh"

// Overview of operation
// - apply only supply voltages the detected card accepts, refuse others
// - control register bits 31..8 and 3 read as zero
// - policy clear: idle action only when idle and host clock stopping
// - policy set: idle action whenever the socket is idle
// - program voltage codes: off, 12, 5, 3.3, two alternates, reserved
// - card access flag is sticky, reset zero, cleared by reading
// - clock changed flag reads one while card clock is not normal
// - unlock bit gates the idle clock action; clear means no control
// - enabled with action zero: card clock may be stopped while idle
// - enabled with action one: card clock divided by sixteen while idle
// - management register reserved bits read as zero
// - forcing a voltage class disables the control register, unless the same write also requests interrogate
// - interrogate request re-checks the card and re-enables control
module card_socket_power_clock_ctrl #(
	parameter SLOW_DIV = `SLOW_DIVIDE,
	parameter DIV_W = `SLOW_DIV_W
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire [7:0] supply_code_ok,
	input wire [7:0] prog_code_ok,
	input wire card_access,
	input wire socket_idle,
	input wire host_clk_stopping,
	output reg [2:0] card_supply_request,
	output reg [2:0] program_voltage_request,
	output reg ctrl_enabled,
	output reg interrogate_card_again,
	output reg card_clk_en,
	output reg card_clk_slowed,
	output reg card_clk_halted
);

	localparam [1:0] CLK_RUN = 2'h0;
	localparam [1:0] CLK_STOP = 2'h1;
	localparam [1:0] CLK_SLOW = 2'h2;
	localparam integer DIV_LAST = SLOW_DIV - 1;

	// stored software state
	reg clock_halt_policy_r;
	reg [2:0] supply_req_r;
	reg [2:0] prog_req_r;
	reg clock_action_unlock_r;
	reg idle_clock_action_r;
	reg card_access_seen_r;
	reg clock_changed_flag_r;
	reg [1:0] clk_state_r;
	reg [1:0] clk_state_nxt;
	reg [DIV_W-1:0] div_cnt_r;
	reg card_access_seen_nxt;
	reg clk_en_nxt;
	reg [31:0] rd_value;

	wire wr_ctrl;
	wire wr_pm;
	wire wr_force;
	wire rd_pm;
	wire force_vclass;
	wire force_interrogate;
	wire may_idle_act;
	wire [31:0] ctrl_wr_value;
	wire [31:0] pm_wr_value;

	// a code is acceptable when it is off or the card reports support
	function code_ok;
		input [2:0] code;
		input [7:0] caps;
		begin
			code_ok = (code == `VOLT_OFF) | caps[code];
		end
	endfunction

	// reserved program codes are never driven to the switch
	function prog_legal;
		input [2:0] code;
		begin
			prog_legal = (code != `VOLT_RSVD_A) && (code != `VOLT_RSVD_B);
		end
	endfunction

	// address decode for the plain register port
	assign wr_ctrl = reg_wr && (reg_addr == `ADDR_SOCKET_CTRL);
	assign wr_pm = reg_wr && (reg_addr == `ADDR_POWER_MGMT);
	assign wr_force = reg_wr && (reg_addr == `ADDR_FORCE_EVENT);
	assign rd_pm = reg_rd && (reg_addr == `ADDR_POWER_MGMT);

	// only writable positions of the write data survive
	assign ctrl_wr_value = reg_wdata & `CTRL_WR_MASK;
	assign pm_wr_value = reg_wdata & `PM_WR_MASK;

	// force event writes that steer the control register
	assign force_vclass =
		wr_force && (|reg_wdata[`FORCE_VCLASS_MSB:`FORCE_VCLASS_LSB]);
	assign force_interrogate = wr_force && reg_wdata[`FORCE_INTERROGATE_BIT];

	// idle action may be tried only when policy and idle allow it
	assign may_idle_act = clock_action_unlock_r && socket_idle &&
		(clock_halt_policy_r || host_clk_stopping);

	// voltage and clock control register storage
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			clock_halt_policy_r <= 1'b0;
			supply_req_r <= 3'h0;
			prog_req_r <= 3'h0;
		end
		else if (wr_ctrl)
		begin
			clock_halt_policy_r <= ctrl_wr_value[`CTRL_HALT_POLICY_BIT];
			supply_req_r <= ctrl_wr_value[`CTRL_SUPPLY_MSB:`CTRL_SUPPLY_LSB];
			prog_req_r <= ctrl_wr_value[`CTRL_PROG_MSB:`CTRL_PROG_LSB];
		end
	end

	// idle clock management register storage
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			clock_action_unlock_r <= 1'b0;
			idle_clock_action_r <= 1'b0;
		end
		else if (wr_pm)
		begin
			clock_action_unlock_r <= pm_wr_value[`PM_UNLOCK_BIT];
			idle_clock_action_r <= pm_wr_value[`PM_ACTION_BIT];
		end
	end

	// sticky access flag; a new access beats the read that clears it
	always @*
	begin
		card_access_seen_nxt = card_access_seen_r;
		if (rd_pm)
		begin
			card_access_seen_nxt = 1'b0;
		end
		if (card_access)
		begin
			card_access_seen_nxt = 1'b1;
		end
	end

	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			card_access_seen_r <= 1'b0;
		end
		else
		begin
			card_access_seen_r <= card_access_seen_nxt;
		end
	end

	// forced voltage class disables control until a re-interrogation;
	// a write holding both takes the re-enable, since it also re-checks
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			ctrl_enabled <= 1'b1;
			interrogate_card_again <= 1'b0;
		end
		else
		begin
			interrogate_card_again <= force_interrogate;
			if (force_interrogate)
			begin
				ctrl_enabled <= 1'b1;
			end
			else if (force_vclass)
			begin
				ctrl_enabled <= 1'b0;
			end
		end
	end

	// drive the socket power switch; while control is disabled the
	// switch keeps its last setting so a forced class cannot move it
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			card_supply_request <= `VOLT_OFF;
			program_voltage_request <= `VOLT_OFF;
		end
		else if (ctrl_enabled)
		begin
			if (code_ok(supply_req_r, supply_code_ok))
			begin
				card_supply_request <= supply_req_r;
			end
			else
			begin
				card_supply_request <= `VOLT_OFF;
			end
			if (prog_legal(prog_req_r) && code_ok(prog_req_r, prog_code_ok))
			begin
				program_voltage_request <= prog_req_r;
			end
			else
			begin
				program_voltage_request <= `VOLT_OFF;
			end
		end
	end

	// card clock mode: run, stopped or slowed while idle
	always @*
	begin
		clk_state_nxt = CLK_RUN;
		case (clk_state_r)
			CLK_RUN:
			begin
				if (may_idle_act && idle_clock_action_r)
				begin
					clk_state_nxt = CLK_SLOW;
				end
				else if (may_idle_act)
				begin
					clk_state_nxt = CLK_STOP;
				end
			end
			CLK_STOP:
			begin
				if (may_idle_act && idle_clock_action_r)
				begin
					clk_state_nxt = CLK_SLOW;
				end
				else if (may_idle_act)
				begin
					clk_state_nxt = CLK_STOP;
				end
			end
			CLK_SLOW:
			begin
				if (may_idle_act && !idle_clock_action_r)
				begin
					clk_state_nxt = CLK_STOP;
				end
				else if (may_idle_act)
				begin
					clk_state_nxt = CLK_SLOW;
				end
			end
			default:
			begin
				clk_state_nxt = CLK_RUN;
			end
		endcase
	end

	// clock enable pattern for the next state
	always @*
	begin
		clk_en_nxt = 1'b1;
		case (clk_state_nxt)
			CLK_STOP:
			begin
				clk_en_nxt = 1'b0;
			end
			CLK_SLOW:
			begin
				// one enabled edge out of every SLOW_DIV
				clk_en_nxt = (clk_state_r == CLK_SLOW) &&
					(div_cnt_r == DIV_LAST[DIV_W-1:0]);
			end
			default:
			begin
				clk_en_nxt = 1'b1;
			end
		endcase
	end

	// divider restarts on every entry to slow mode so spacing is exact
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			div_cnt_r <= {DIV_W{1'b0}};
		end
		else if ((clk_state_r == CLK_SLOW) && (clk_state_nxt == CLK_SLOW))
		begin
			div_cnt_r <= div_cnt_r + 1'b1;
		end
		else
		begin
			div_cnt_r <= {DIV_W{1'b0}};
		end
	end

	// clock state and its registered views
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			clk_state_r <= CLK_RUN;
			card_clk_en <= 1'b1;
			card_clk_slowed <= 1'b0;
			card_clk_halted <= 1'b0;
			clock_changed_flag_r <= 1'b0;
		end
		else
		begin
			clk_state_r <= clk_state_nxt;
			card_clk_en <= clk_en_nxt;
			card_clk_slowed <= (clk_state_nxt == CLK_SLOW);
			card_clk_halted <= (clk_state_nxt == CLK_STOP);
			clock_changed_flag_r <= (clk_state_nxt != CLK_RUN);
		end
	end

	// read value; reserved positions stay zero by construction
	always @*
	begin
		rd_value = 32'h00000000;
		case (reg_addr)
			`ADDR_SOCKET_CTRL:
			begin
				rd_value[`CTRL_HALT_POLICY_BIT] = clock_halt_policy_r;
				rd_value[`CTRL_SUPPLY_MSB:`CTRL_SUPPLY_LSB] = supply_req_r;
				rd_value[`CTRL_PROG_MSB:`CTRL_PROG_LSB] = prog_req_r;
			end
			`ADDR_POWER_MGMT:
			begin
				rd_value[`PM_ACCESS_BIT] = card_access_seen_r;
				rd_value[`PM_CHANGED_BIT] = clock_changed_flag_r;
				rd_value[`PM_UNLOCK_BIT] = clock_action_unlock_r;
				rd_value[`PM_ACTION_BIT] = idle_clock_action_r;
			end
			default:
			begin
				// force event is write-only; unmapped reads give zero
				rd_value = 32'h00000000;
			end
		endcase
	end

	// read data stand only in the cycle after the strobe
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			reg_rdata <= 32'h00000000;
		end
		else if (reg_rd)
		begin
			reg_rdata <= rd_value;
		end
		else
		begin
			reg_rdata <= 32'h00000000;
		end
	end

endmodule

// >>> tb/card_socket_power_clock_ctrl_monitor.sv
`timescale 1ns/1ps
module card_socket_power_clock_ctrl_monitor #(
	parameter SLOW_DIV = 16,
	parameter DIV_W = 4
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire [7:0] supply_code_ok,
	input wire [7:0] prog_code_ok,
	input wire card_access,
	input wire socket_idle,
	input wire card_clk_en,
	input wire card_clk_slowed,
	input wire card_clk_halted,
	input wire ctrl_enabled,
	input wire interrogate_card_again,
	input wire [2:0] card_supply_request,
	input wire [2:0] program_voltage_request
);
	reg [7:0] sok_r;
	reg [7:0] pok_r;
	reg [DIV_W-1:0] slow_cnt_r;
	// caps lag one edge like the requests; the count wraps only at 2**DIV_W
	always @(posedge sys_clk)
	begin
		sok_r <= supply_code_ok;
		pok_r <= prog_code_ok;
		if (sys_rst || !card_clk_slowed)
			slow_cnt_r <= {DIV_W{1'b0}};
		else
			slow_cnt_r <= slow_cnt_r + 1'b1;
	end
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	property p_ctrl_zero;
		$past(reg_rd) && $past(reg_addr) == 8'h10
			|-> (reg_rdata & 32'hffffff08) == 32'h0;
	endproperty
	a_ctrl_zero: assert property (p_ctrl_zero)
		else $error("control reserved bits not zero");
	property p_pm_zero;
		$past(reg_rd) && $past(reg_addr) == 8'h20
			|-> (reg_rdata & 32'hfcfefffe) == 32'h0;
	endproperty
	a_pm_zero: assert property (p_pm_zero)
		else $error("management reserved bits not zero");
	property p_sup;
		$past(ctrl_enabled) && card_supply_request != 3'h0
			|-> sok_r[card_supply_request];
	endproperty
	a_sup: assert property (p_sup)
		else $error("supply applied that card refuses");
	property p_prg;
		$past(ctrl_enabled) && program_voltage_request != 3'h0
			|-> program_voltage_request < 3'h6
			&& pok_r[program_voltage_request];
	endproperty
	a_prg: assert property (p_prg)
		else $error("bad program voltage applied");
	// clock mode registers from the inputs of the edge before
	property p_idle;
		card_clk_halted || card_clk_slowed |-> $past(socket_idle);
	endproperty
	a_idle: assert property (p_idle)
		else $error("card clock changed while socket busy");
	property p_slow;
		card_clk_slowed && $past(card_clk_slowed)
			|-> card_clk_en == (slow_cnt_r == 0);
	endproperty
	a_slow: assert property (p_slow)
		else $error("slowed clock not one in sixteen");
	property p_halt;
		card_clk_halted |-> !card_clk_en && !card_clk_slowed;
	endproperty
	a_halt: assert property (p_halt)
		else $error("halted clock still enabled");
	property p_mode;
		$past(reg_rd) && $past(reg_addr) == 8'h20
			|-> reg_rdata[24] == $past(card_clk_halted || card_clk_slowed);
	endproperty
	a_mode: assert property (p_mode)
		else $error("clock changed flag wrong");
	property p_acc;
		card_access ##1 reg_rd && reg_addr == 8'h20 |=> reg_rdata[25];
	endproperty
	a_acc: assert property (p_acc)
		else $error("card access flag not set");
	property p_vcls;
		reg_wr && reg_addr == 8'h0c && !reg_wdata[14]
			&& reg_wdata[13:10] != 4'h0
			|=> !ctrl_enabled ##1 $stable(card_supply_request);
	endproperty
	a_vcls: assert property (p_vcls)
		else $error("forced class left control on");
	property p_intg;
		reg_wr && reg_addr == 8'h0c && reg_wdata[14]
			|=> interrogate_card_again && ctrl_enabled;
	endproperty
	a_intg: assert property (p_intg)
		else $error("interrogate pulse or enable missing");
endmodule
bind card_socket_power_clock_ctrl card_socket_power_clock_ctrl_monitor #(
	.SLOW_DIV(SLOW_DIV),
	.DIV_W(DIV_W)
) u_card_socket_power_clock_ctrl_monitor (.sys_clk, .sys_rst, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .supply_code_ok,
	.prog_code_ok, .card_access, .socket_idle, .card_clk_en, .card_clk_slowed,
	.card_clk_halted, .ctrl_enabled, .interrogate_card_again,
	.card_supply_request, .program_voltage_request);

// >>> tb/card_socket_partner.sv
`timescale 1ns/1ps
// the card and its access activity; accepted codes are fixed per card
module card_socket_partner #(
	parameter SUP_OK = 8'hf5,
	parameter PRG_OK = 8'h2f
) (
	input wire sys_clk,
	input wire busy,
	output wire [7:0] supply_code_ok,
	output wire [7:0] prog_code_ok,
	output reg card_access,
	output reg socket_idle
);
	assign supply_code_ok = SUP_OK;
	assign prog_code_ok = PRG_OK;
	// a busy card is accessed and keeps the socket out of idle
	always @(posedge sys_clk)
	begin
		card_access <= busy;
		socket_idle <= !busy;
	end
endmodule

// >>> tb/card_socket_power_clock_ctrl_tb.sv
`timescale 1ns/1ps
module card_socket_power_clock_ctrl_tb;
	localparam [7:0] SOK = 8'hf5;
	localparam [7:0] POK = 8'h2f;
	reg sys_clk = 1'b0;
	reg sys_rst = 1'b1;
	reg [7:0] reg_addr = 8'h00;
	reg [31:0] reg_wdata = 32'h0;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg host_clk_stopping = 1'b0;
	reg busy = 1'b0;
	reg pulse = 1'b0;
	integer error_cnt = 0;
	integer n_tests = 0;
	integer i;
	integer k;
	wire [31:0] reg_rdata;
	wire [7:0] supply_code_ok;
	wire [7:0] prog_code_ok;
	wire [2:0] card_supply_request;
	wire [2:0] program_voltage_request;
	wire card_access, socket_idle, ctrl_enabled, interrogate_card_again;
	wire card_clk_en, card_clk_slowed, card_clk_halted;
	always #5 sys_clk = ~sys_clk;
	card_socket_partner #(.SUP_OK(SOK), .PRG_OK(POK)) u_card_socket_partner (
		.sys_clk, .busy, .supply_code_ok, .prog_code_ok, .card_access,
		.socket_idle);
	card_socket_power_clock_ctrl u_card_socket_power_clock_ctrl (.sys_clk,
		.sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.supply_code_ok, .prog_code_ok, .card_access, .socket_idle,
		.host_clk_stopping, .card_supply_request, .program_voltage_request,
		.ctrl_enabled, .interrogate_card_again, .card_clk_en,
		.card_clk_slowed, .card_clk_halted);
	task chk(input [31:0] seen, input [31:0] exp);
	begin
		n_tests = n_tests + 1;
		if (seen !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	end
	endtask
	// outputs settle one edge after the write; two keep levels safe
	task wr(input [7:0] a, input [31:0] d);
	begin
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
		pulse = interrogate_card_again;
		repeat (2) @(posedge sys_clk);
		#1;
	end
	endtask
	task rd(input [7:0] a, input [31:0] exp);
	begin
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	end
	endtask
	task hold(input integer n);
	begin
		repeat (n) @(posedge sys_clk);
	end
	endtask
	task complete_run;
	begin
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	initial
	begin
		hold(8);
		sys_rst <= 1'b0;
		rd(8'h10, 32'h0);
		rd(8'h20, 32'h0);
		wr(8'h10, 32'hffffffff);
		rd(8'h10, 32'hf7);
		// same code in both fields, all eight codes
		for (i = 0; i < 8; i = i + 1)
		begin
			wr(8'h10, i * 17);
			chk(card_supply_request, (i == 0 || SOK[i]) ? i : 0);
			chk(program_voltage_request, (i < 6 && POK[i]) ? i : 0);
		end
		wr(8'h20, 32'hffffffff);
		rd(8'h20, 32'h10001);
		chk(card_clk_slowed, 1'b0);
		@(posedge sys_clk);
		host_clk_stopping <= 1'b1;
		hold(3);
		k = 0;
		// any 32 slowed cycles after the entry cycle hold exactly two enables
		for (i = 0; i < 32; i = i + 1)
		begin
			@(posedge sys_clk);
			#1;
			k = k + card_clk_en;
		end
		chk(k, 2);
		rd(8'h20, 32'h1010001);
		wr(8'h20, 32'h10000);
		chk(card_clk_halted, 1'b1);
		wr(8'h20, 32'h1);
		chk({card_clk_slowed, card_clk_halted}, 2'b00);
		@(posedge sys_clk);
		host_clk_stopping <= 1'b0;
		wr(8'h20, 32'h10000);
		chk(card_clk_halted, 1'b0);
		wr(8'h10, 32'h80);
		chk(card_clk_halted, 1'b1);
		busy <= 1'b1;
		hold(3);
		rd(8'h20, 32'h2010000);
		busy <= 1'b0;
		hold(3);
		rd(8'h20, 32'h3010000);
		rd(8'h20, 32'h1010000);
		wr(8'h0c, 32'h400);
		chk(ctrl_enabled, 1'b0);
		wr(8'h10, 32'h22);
		chk(card_supply_request, 3'h0);
		wr(8'h0c, 32'h4000);
		chk({pulse, ctrl_enabled}, 2'b11);
		chk(card_supply_request, 3'h2);
		rd(8'h0c, 32'h0);
		wr(8'h44, 32'hffffffff);
		rd(8'h44, 32'h0);
		complete_run;
	end
endmodule
